// File: dv/host_serial_model.sv
// Purpose: Host computer on the serial link, sending and receiving characters.
// Assumes: Bit time is BAUD_DIV core clocks.
// Notes:   The line idles at mark; there is no timing jitter.
`default_nettype none
module host_serial_model #(
  parameter int BAUD_DIV = 16
) (
  input  wire logic core_clk,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] lastChar;
  logic       parityOk;
  logic [8:0] bits;
  int         nChars;
  initial begin
    rxd = 1'b1;
    nChars = 0;
  end
  task automatic sendChar(input logic [6:0] c);
    logic [9:0] frame;
    frame = {1'b1, ^c, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= frame[i];
      repeat (BAUD_DIV) @(posedge core_clk);
    end
  endtask
  // Sampling at mid bit keeps the model tolerant of a one-cycle start offset.
  initial forever begin
    @(negedge txd);
    repeat (BAUD_DIV / 2) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BAUD_DIV) @(posedge core_clk);
      bits[i] = txd;
    end
    lastChar = bits[6:0];
    parityOk = !(^bits[7:0]) && bits[8];
    nChars++;
  end
endmodule
`default_nettype wire

// File: dv/tb_ups_status_remote_ctrl.sv
// Purpose: Self-checking bench for the supply status and remote-control block.
// Assumes: Short second and bit counts through parameters.
// Notes:   Registers are reached over AXI4-Lite tasks.
`default_nettype none
module tb_ups_status_remote_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import ups_pkg::*;
  localparam int SEC  = 20;
  localparam int BDIV = 16;
  logic        core_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rxd, txd, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        outputRegulated, acInputFailed, tempCritical, combat_override_cmd;
  logic        remote_power_switch, remote_bypass_switch, unitOn, bypassActive, chargerEnable;
  logic        output_good_n, running_on_battery_n, battery_charge_low_n, over_temperature_n;
  logic        overTempLed, alarmBeep, led0;
  logic [6:0]  chargePercent;
  logic signed [11:0] sineRef;
  int          n_mismatch, n_checks, cyc, i, blinks;

  ups_status_remote_ctrl #(.SEC_CYCLES(SEC), .BAUD_DIV(BDIV)) i_ups_status_remote_ctrl (.*);
  host_serial_model #(.BAUD_DIV(BDIV)) i_host_serial_model (.core_clk(core_clk), .txd(txd), .rxd(rxd));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge core_clk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
      if (s_axi_bvalid) break;
    end
    chk(s_axi_bvalid, 1'b1, "write answer");
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge core_clk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      if (s_axi_rvalid) break;
    end
    chk(s_axi_rvalid, 1'b1, "read answer");
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
    {outputRegulated, acInputFailed, chargePercent, tempCritical, combat_override_cmd} <= '0;
    remote_power_switch  <= 1'b0;
    remote_bypass_switch <= 1'b1;
    srst <= 1'b1;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd(ADDR_CTRL);
    chk(d, 32'h0, "control reset");
    chk(sineRef > 0, 1'b1, "sine positive");
    rd(ADDR_STATUS);
    chk(d[1:0], ST_OFF, "off with power switch open");
    rd(8'h18);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
    remote_power_switch <= 1'b1;
    // Charge steps 34 and 35 straddle the battery-low threshold.
    for (i = 0; i < 4; i++) begin
      outputRegulated <= i[0];
      acInputFailed   <= i[1];
      chargePercent   <= 7'h22 + 7'(i[0]);
      repeat (3) @(posedge core_clk);
      chk(output_good_n, !i[0], "output good line");
      chk(running_on_battery_n, !i[1], "on battery line");
      chk(battery_charge_low_n, i[0], "battery low line");
    end
    acInputFailed <= 1'b0;
    rd(ADDR_IRQ_STAT);
    acInputFailed <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0, "masked interrupt");
    axw(ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b1, "interrupt raised");
    rd(ADDR_IRQ_STAT);
    chk(d[0], 1'b1, "battery event bit");
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0, "interrupt cleared by read");
    rd(ADDR_IRQ_MASK);
    chk(d, 32'h1, "mask readback");
    axw(ADDR_TX_DATA, 32'h55);
    for (i = 0; i < 400 && i_host_serial_model.nChars == 0; i++) @(posedge core_clk);
    chk({i_host_serial_model.parityOk, i_host_serial_model.lastChar}, 8'hD5, "sent char");
    i_host_serial_model.sendChar(7'h2A);
    rd(ADDR_RX_DATA);
    chk(d[8:0], 9'h12A, "received char");
    remote_bypass_switch <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({bypassActive, output_good_n, running_on_battery_n, over_temperature_n}, 4'hF, "bypass");
    remote_bypass_switch <= 1'b1;
    remote_power_switch  <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({unitOn, bypassActive}, 2'h0, "power switch open");
    axw(ADDR_CTRL, 32'h2);
    remote_power_switch <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(unitOn, 1'b0, "sw shutdown");
    axw(ADDR_CTRL, 32'h0);
    combat_override_cmd <= 1'b1;
    tempCritical        <= 1'b1;
    blinks = 0;
    led0 = 1'b0;
    for (i = 0; i < 190 * SEC; i++) begin
      @(posedge core_clk);
      blinks += int'(overTempLed !== led0);
      led0 = overTempLed;
    end
    chk({unitOn, over_temperature_n, chargerEnable}, 3'h4, "override keeps running");
    chk(blinks >= 188 && blinks <= 191, 1'b1, "one toggle per second");
    combat_override_cmd <= 1'b0;
    tempCritical        <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(chargerEnable, 1'b1, "charger back when cool");
    tempCritical <= 1'b1;
    for (i = 0; i < 182 * SEC && unitOn === 1'b1; i++) @(posedge core_clk);
    chk(i >= 179 * SEC && i <= 180 * SEC + 2, 1'b1, "shutdown after 180 s");
    chk({bypassActive, output_good_n, over_temperature_n}, 3'h3, "shut down, lines open");
    for (i = 0; i < 3 * SEC && bypassActive !== 1'b1; i++) @(posedge core_clk);
    chk(i >= SEC && i <= 2 * SEC + 2, 1'b1, "bypass 2 s after shutdown");
    wrap_up();
  end
endmodule
`default_nettype wire

// File: dv/ups_status_remote_ctrl_assertions.sv
// Purpose: Concurrent checks on the status lines, switches and override handling.
// Assumes: Sees only the top module ports; one clock domain.
// Notes:   Discretes and state are registered on the edge after their cause.
`default_nettype none
module ups_status_remote_ctrl_checker
  import ups_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       outputRegulated,
  input wire logic       acInputFailed,
  input wire logic [6:0] chargePercent,
  input wire logic       tempCritical,
  input wire logic       combat_override_cmd,
  input wire logic       remote_power_switch,
  input wire logic       remote_bypass_switch,
  input wire logic       output_good_n,
  input wire logic       running_on_battery_n,
  input wire logic       battery_charge_low_n,
  input wire logic       over_temperature_n,
  input wire logic       unitOn,
  input wire logic       bypassActive,
  input wire logic       chargerEnable,
  input wire logic       overTempLed,
  input wire logic       alarmBeep
);
  logic allOpen;
  assign allOpen = &{output_good_n, running_on_battery_n, battery_charge_low_n, over_temperature_n};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  lines_released_a: assert property (!unitOn |-> allOpen)
    else $error("discrete pulled while not running");
  good_line_a: assert property (unitOn |-> output_good_n == !$past(outputRegulated))
    else $error("output good line wrong");
  battery_line_a: assert property (unitOn |-> running_on_battery_n == !$past(acInputFailed))
    else $error("on battery line wrong");
  charge_low_a: assert property (unitOn |-> battery_charge_low_n == ($past(chargePercent) >= BATT_LOW_PCT))
    else $error("battery low line wrong");
  temp_line_a: assert property (unitOn |-> over_temperature_n == !$past(tempCritical))
    else $error("over temperature line wrong");
  charger_off_a: assert property ($past(combat_override_cmd) && $past(tempCritical) |-> !chargerEnable)
    else $error("charger enabled under override heat");
  override_run_a: assert property (combat_override_cmd && unitOn && remote_power_switch && remote_bypass_switch
    |=> unitOn)
    else $error("unit stopped under override");
  power_open_a: assert property (!remote_power_switch |=> !unitOn && !bypassActive)
    else $error("unit alive with power switch open");
  bypass_open_a: assert property (unitOn && remote_power_switch && !remote_bypass_switch |=> bypassActive)
    else $error("no bypass with bypass switch open");
  alarm_blink_a: assert property (overTempLed |-> alarmBeep && $past(tempCritical))
    else $error("indicator lit without heat");

  cover property (unitOn && !over_temperature_n);
  cover property (bypassActive);
  cover property (unitOn && !chargerEnable);
endmodule

bind ups_status_remote_ctrl ups_status_remote_ctrl_checker i_ups_status_remote_ctrl_checker (
  .core_clk, .srst, .outputRegulated, .acInputFailed, .chargePercent, .tempCritical, .combat_override_cmd,
  .remote_power_switch, .remote_bypass_switch, .output_good_n, .running_on_battery_n, .battery_charge_low_n,
  .over_temperature_n, .unitOn, .bypassActive, .chargerEnable, .overTempLed, .alarmBeep
);
`default_nettype wire

// File: hw/ups_serial_link.sv
// Purpose: Full duplex character engine, seven data bits, even parity, one stop bit.
// Assumes: rxd is synchronous to core_clk.
// Notes:   A start request while busy is dropped; the controller checks txBusy first.
`default_nettype none
module ups_serial_link #(
  parameter int BAUD_DIV = ups_pkg::BAUD_DIV
) (
  input  wire logic core_clk,
  input  wire logic srst,
  serial_if.link    port,
  input  wire logic rxd,
  output logic      txd
);
  import ups_pkg::*;
  localparam logic [15:0] BIT_TOP  = 16'(BAUD_DIV - 1);
  localparam logic [15:0] HALF_TOP = 16'(BAUD_DIV / 2);

  logic [9:0]  txShiftReg, txShiftNext;
  logic [3:0]  txBitsReg, txBitsNext, rxBitsReg, rxBitsNext;
  logic [15:0] txCntReg, txCntNext, rxCntReg, rxCntNext;
  logic [9:0]  rxShiftReg, rxShiftNext;
  logic [9:0]  frame;
  logic [6:0]  rxDataReg, rxDataNext;
  logic        rxStrobeReg, rxStrobeNext, rxErrReg, rxErrNext;

  always_comb begin
    txShiftNext = txShiftReg;
    txBitsNext  = txBitsReg;
    txCntNext   = txCntReg;
    if (txBitsReg == 4'h0) begin
      if (port.txStart) begin
        txShiftNext = {1'b1, ^port.txData, port.txData, 1'b0};
        txBitsNext  = 4'hA;
        txCntNext   = BIT_TOP;
      end
    end else if (txCntReg == 16'h0000) begin
      txShiftNext = {1'b1, txShiftReg[9:1]};
      txBitsNext  = txBitsReg - 4'h1;
      txCntNext   = BIT_TOP;
    end else begin
      txCntNext = txCntReg - 16'h0001;
    end
  end

  always_comb begin
    rxShiftNext  = rxShiftReg;
    rxBitsNext   = rxBitsReg;
    rxCntNext    = rxCntReg;
    rxDataNext   = rxDataReg;
    rxStrobeNext = 1'b0;
    rxErrNext    = 1'b0;
    frame        = {rxd, rxShiftReg[9:1]};
    if (rxBitsReg == 4'h0) begin
      if (!rxd) begin
        rxBitsNext = 4'hA;
        rxCntNext  = HALF_TOP;
      end
    end else if (rxCntReg != 16'h0000) begin
      rxCntNext = rxCntReg - 16'h0001;
    end else if (rxBitsReg == 4'hA && rxd) begin
      // A start bit gone high at mid-bit was a glitch, not a character.
      rxBitsNext = 4'h0;
    end else begin
      rxShiftNext = frame;
      rxBitsNext  = rxBitsReg - 4'h1;
      rxCntNext   = BIT_TOP;
      if (rxBitsReg == 4'h1) begin
        rxDataNext   = frame[7:1];
        rxStrobeNext = 1'b1;
        rxErrNext    = (^frame[8:1]) | ~frame[9];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      txShiftReg  <= 10'h3FF;
      txBitsReg   <= 4'h0;
      txCntReg    <= 16'h0000;
      rxShiftReg  <= 10'h000;
      rxBitsReg   <= 4'h0;
      rxCntReg    <= 16'h0000;
      rxDataReg   <= 7'h00;
      rxStrobeReg <= 1'b0;
      rxErrReg    <= 1'b0;
    end else begin
      txShiftReg  <= txShiftNext;
      txBitsReg   <= txBitsNext;
      txCntReg    <= txCntNext;
      rxShiftReg  <= rxShiftNext;
      rxBitsReg   <= rxBitsNext;
      rxCntReg    <= rxCntNext;
      rxDataReg   <= rxDataNext;
      rxStrobeReg <= rxStrobeNext;
      rxErrReg    <= rxErrNext;
    end
  end

  assign txd              = txShiftReg[0];
  assign port.txBusy      = (txBitsReg != 4'h0);
  assign port.rxData      = rxDataReg;
  assign port.rxStrobe    = rxStrobeReg;
  assign port.rxParityErr = rxErrReg;
endmodule
`default_nettype wire

// File: hw/ups_status_remote_ctrl.sv
// Purpose: Status lines, remote switches, over-temperature handling, sine reference and host link.
// Assumes: All inputs synchronous to core_clk; switch inputs high when closed.
// Notes:   Discrete outputs are high when open, low when pulled.
// What this block does
// - Discrete status is valid only while running and not in bypass.
// - Output-good pulled low while AC output regulated, else open.
// - On-battery pulled low while running from battery after AC input failure.
// - Battery-low pulled low when charge below thirty-five percent.
// - Over-temperature pulled low when critical; three minutes persisting shuts down.
// - Combat override high suppresses the over-temperature shutdown.
// - Under override, over-temperature still reported and unit keeps running.
// - Override plus over-temperature disables charger until temperature safe.
// - Remote power switch open shuts the unit and battery packs down.
// - Remote bypass switch open transfers the unit to bypass.
// - Host link: 1200 baud, seven data bits, even parity, one stop.
// - A 60 Hz sine reference synthesized from the crystal clock.
// - Over-temperature blinks indicator and sounds alarm once per second.
// - After over-temperature shutdown, bypass follows about two seconds later.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module ups_status_remote_ctrl #(
  parameter int SEC_CYCLES = ups_pkg::SECOND_CYCLES,
  parameter int BAUD_DIV   = ups_pkg::BAUD_DIV
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        outputRegulated,
  input  wire logic        acInputFailed,
  input  wire logic [6:0]  chargePercent,
  input  wire logic        tempCritical,
  input  wire logic        combat_override_cmd,
  input  wire logic        remote_power_switch,
  input  wire logic        remote_bypass_switch,
  input  wire logic        rxd,
  output logic             txd,
  output logic             output_good_n,
  output logic             running_on_battery_n,
  output logic             battery_charge_low_n,
  output logic             over_temperature_n,
  output logic             unitOn,
  output logic             bypassActive,
  output logic             chargerEnable,
  output logic             overTempLed,
  output logic             alarmBeep,
  output logic signed [11:0] sineRef,
  output logic             irq
);
  import ups_pkg::*;
  localparam logic [31:0] SEC_TOP = 32'(SEC_CYCLES - 1);
  localparam logic [7:0]  OT_LIMIT = 8'(OT_SHUTDOWN_S);
  localparam logic [1:0]  BYP_DELAY = 2'(BYPASS_DELAY_S);
  localparam logic [10:0] SINE_Q [16] = '{
    11'h064, 11'h12C, 11'h1F1, 11'h2B2, 11'h36B, 11'h41C, 11'h4C3, 11'h55F,
    11'h5ED, 11'h66C, 11'h6DC, 11'h73A, 11'h787, 11'h7C2, 11'h7E9, 11'h7FD};

  serial_if ser ();

  ups_serial_link #(.BAUD_DIV(BAUD_DIV)) link (
    .core_clk (core_clk),
    .srst     (srst),
    .port     (ser.link),
    .rxd      (rxd),
    .txd      (txd)
  );

  // Operating state and its timers.
  ups_state_t  stateReg, stateNext;
  logic [31:0] secCntReg, secCntNext;
  logic [7:0]  otSecsReg, otSecsNext;
  logic [1:0]  delayReg, delayNext;
  logic        otLatchReg, otLatchNext, blinkReg, blinkNext;
  logic        secTick;
  logic [1:0]  ctrlReg, ctrlNext;

  assign secTick = (secCntReg == SEC_TOP);

  always_comb begin
    stateNext   = stateReg;
    otLatchNext = otLatchReg;
    delayNext   = delayReg;
    secCntNext  = secTick ? 32'h0000_0000 : secCntReg + 32'h0000_0001;
    otSecsNext  = otSecsReg;
    blinkNext   = 1'b0;
    if (stateReg == ST_ONLINE && tempCritical) begin
      blinkNext = secTick ? ~blinkReg : blinkReg;
      if (secTick && otSecsReg != OT_LIMIT) otSecsNext = otSecsReg + 8'h01;
    end else begin
      otSecsNext = 8'h00;
    end
    unique case (stateReg)
      ST_OFF: begin
        otLatchNext = 1'b0;
        if (remote_power_switch && !ctrlReg[CTRL_SW_SHUTDOWN]) stateNext = ST_ONLINE;
      end
      ST_ONLINE: begin
        if (!remote_bypass_switch || ctrlReg[CTRL_SW_BYPASS]) begin
          stateNext = ST_BYPASS;
        end else if (tempCritical && otSecsReg == OT_LIMIT && !combat_override_cmd) begin
          stateNext = ST_OT_SHUT;
          delayNext = 2'h0;
        end
      end
      ST_OT_SHUT: begin
        if (secTick) delayNext = delayReg + 2'h1;
        if (secTick && delayReg == BYP_DELAY - 2'h1) begin
          stateNext   = ST_BYPASS;
          otLatchNext = 1'b1;
        end
      end
      ST_BYPASS: begin
        // After a thermal shutdown only a power cycle brings the inverter back.
        if (remote_bypass_switch && !ctrlReg[CTRL_SW_BYPASS] && !otLatchReg) stateNext = ST_ONLINE;
      end
    endcase
    if (!remote_power_switch || ctrlReg[CTRL_SW_SHUTDOWN]) stateNext = ST_OFF;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stateReg   <= ST_OFF;
      secCntReg  <= 32'h0000_0000;
      otSecsReg  <= 8'h00;
      delayReg   <= 2'h0;
      otLatchReg <= 1'b0;
      blinkReg   <= 1'b0;
    end else begin
      stateReg   <= stateNext;
      secCntReg  <= secCntNext;
      otSecsReg  <= otSecsNext;
      delayReg   <= delayNext;
      otLatchReg <= otLatchNext;
      blinkReg   <= blinkNext;
    end
  end

  // Discrete lines, power outputs and the sine reference.
  logic        validReg, validNext;
  logic [3:0]  pullReg, pullNext;
  logic        chgReg, chgNext;
  logic [31:0] phaseReg, phaseNext;
  logic signed [11:0] sineReg, sineNext;
  logic [3:0]  sineIdx;

  always_comb begin
    validNext = (stateNext == ST_ONLINE);
    pullNext  = 4'h0;
    if (validNext) begin
      pullNext[0] = outputRegulated;
      pullNext[1] = acInputFailed;
      pullNext[2] = (chargePercent < BATT_LOW_PCT);
      pullNext[3] = tempCritical;
    end
    chgNext   = validNext && !(combat_override_cmd && tempCritical);
    phaseNext = phaseReg + SINE_STEP;
    sineIdx   = phaseReg[30] ? ~phaseReg[29:26] : phaseReg[29:26];
    sineNext  = phaseReg[31] ? -$signed({1'b0, SINE_Q[sineIdx]}) : $signed({1'b0, SINE_Q[sineIdx]});
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      validReg <= 1'b0;
      pullReg  <= 4'h0;
      chgReg   <= 1'b0;
      phaseReg <= 32'h0000_0000;
      sineReg  <= 12'sh000;
    end else begin
      validReg <= validNext;
      pullReg  <= pullNext;
      chgReg   <= chgNext;
      phaseReg <= phaseNext;
      sineReg  <= sineNext;
    end
  end

  assign output_good_n        = ~pullReg[0];
  assign running_on_battery_n = ~pullReg[1];
  assign battery_charge_low_n = ~pullReg[2];
  assign over_temperature_n   = ~pullReg[3];
  assign unitOn               = validReg;
  assign bypassActive         = (stateReg == ST_BYPASS);
  assign chargerEnable        = chgReg;
  assign overTempLed          = blinkReg;
  assign alarmBeep            = blinkReg;
  assign sineRef              = sineReg;

  // Register bus slave with sticky interrupt status.
  logic        awHeldReg, awHeldNext, wHeldReg, wHeldNext, bvReg, bvNext, rvReg, rvNext;
  logic [7:0]  awAddrReg, awAddrNext;
  logic [31:0] wDataReg, wDataNext, rdReg, rdNext;
  logic [3:0]  wStrbReg, wStrbNext;
  logic [1:0]  brReg, brNext, rrReg, rrNext;
  logic [IRQ_W-1:0] statReg, statNext, maskReg, maskNext, events;
  logic [6:0]  rxHoldReg, rxHoldNext;
  logic        rxValidReg, rxValidNext, txStartNext, txStartReg;
  logic        doWrite, doRead;

  assign s_axi_awready = !awHeldReg && !bvReg;
  assign s_axi_wready  = !wHeldReg && !bvReg;
  assign s_axi_arready = !rvReg;
  assign doWrite = awHeldReg && wHeldReg && !bvReg;
  assign doRead  = s_axi_arvalid && !rvReg;

  always_comb begin
    awHeldNext  = awHeldReg | (s_axi_awvalid & s_axi_awready);
    wHeldNext   = wHeldReg | (s_axi_wvalid & s_axi_wready);
    awAddrNext  = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awAddrReg;
    wDataNext   = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wDataReg;
    wStrbNext   = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wStrbReg;
    bvNext      = bvReg & ~s_axi_bready;
    brNext      = brReg;
    rvNext      = rvReg & ~s_axi_rready;
    rdNext      = rdReg;
    rrNext      = rrReg;
    ctrlNext    = ctrlReg;
    maskNext    = maskReg;
    txStartNext = 1'b0;
    events = '0;
    events[IRQ_RUNNING_ON_BATTERY_N]     = pullNext[1] & ~pullReg[1];
    events[IRQ_BATT_LOW]    = pullNext[2] & ~pullReg[2];
    events[IRQ_OVER_TEMP]   = pullNext[3] & ~pullReg[3];
    events[IRQ_OT_SHUTDOWN] = (stateNext == ST_OT_SHUT) && (stateReg != ST_OT_SHUT);
    events[IRQ_RX_CHAR]     = ser.rxStrobe;
    events[IRQ_RX_ERROR]    = ser.rxStrobe & ser.rxParityErr;
    statNext    = statReg;
    rxHoldNext  = ser.rxStrobe ? ser.rxData : rxHoldReg;
    rxValidNext = rxValidReg;
    if (doWrite) begin
      awHeldNext = 1'b0;
      wHeldNext  = 1'b0;
      bvNext     = 1'b1;
      brNext     = RESP_OKAY;
      unique case (awAddrReg)
        ADDR_CTRL:     if (wStrbReg[0]) ctrlNext = wDataReg[1:0];
        ADDR_IRQ_MASK: if (wStrbReg[0]) maskNext = wDataReg[IRQ_W-1:0];
        ADDR_TX_DATA:  txStartNext = wStrbReg[0] && !ser.txBusy;
        ADDR_STATUS, ADDR_IRQ_STAT, ADDR_RX_DATA: ;
        default:       brNext = RESP_SLVERR;
      endcase
    end
    if (doRead) begin
      rvNext = 1'b1;
      rrNext = RESP_OKAY;
      rdNext = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_CTRL:     rdNext[1:0] = ctrlReg;
        ADDR_STATUS:   rdNext[15:0] = {otSecsReg, 1'b0, ser.txBusy, otLatchReg, chgReg,
                                       blinkReg, tempCritical, stateReg};
        ADDR_IRQ_STAT: begin
          rdNext[IRQ_W-1:0] = statReg;
          statNext = '0;
        end
        ADDR_IRQ_MASK: rdNext[IRQ_W-1:0] = maskReg;
        ADDR_TX_DATA:  rdNext[8] = ser.txBusy;
        ADDR_RX_DATA: begin
          rdNext[8:0] = {rxValidReg, 1'b0, rxHoldReg};
          rxValidNext = 1'b0;
        end
        default:       rrNext = RESP_SLVERR;
      endcase
    end
    // An event landing on the clearing read stays pending.
    statNext    = statNext | events;
    rxValidNext = rxValidNext | ser.rxStrobe;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      awHeldReg  <= 1'b0;
      wHeldReg   <= 1'b0;
      awAddrReg  <= 8'h00;
      wDataReg   <= 32'h0000_0000;
      wStrbReg   <= 4'h0;
      bvReg      <= 1'b0;
      brReg      <= RESP_OKAY;
      rvReg      <= 1'b0;
      rdReg      <= 32'h0000_0000;
      rrReg      <= RESP_OKAY;
      ctrlReg    <= CTRL_RESET;
      maskReg    <= IRQ_RESET;
      statReg    <= IRQ_RESET;
      rxHoldReg  <= 7'h00;
      rxValidReg <= 1'b0;
      txStartReg <= 1'b0;
    end else begin
      awHeldReg  <= awHeldNext;
      wHeldReg   <= wHeldNext;
      awAddrReg  <= awAddrNext;
      wDataReg   <= wDataNext;
      wStrbReg   <= wStrbNext;
      bvReg      <= bvNext;
      brReg      <= brNext;
      rvReg      <= rvNext;
      rdReg      <= rdNext;
      rrReg      <= rrNext;
      ctrlReg    <= ctrlNext;
      maskReg    <= maskNext;
      statReg    <= statNext;
      rxHoldReg  <= rxHoldNext;
      rxValidReg <= rxValidNext;
      txStartReg <= txStartNext;
    end
  end

  assign ser.txStart  = txStartReg;
  assign ser.txData   = wDataReg[6:0];
  assign s_axi_bvalid = bvReg;
  assign s_axi_bresp  = brReg;
  assign s_axi_rvalid = rvReg;
  assign s_axi_rdata  = rdReg;
  assign s_axi_rresp  = rrReg;
  assign irq          = |(statReg & maskReg);
endmodule
`default_nettype wire

// File: include/serial_if.sv
// Purpose: Character path between the controller and the serial link engine.
// Assumes: One clock domain.
// Notes:   Strobes last one cycle.
`default_nettype none
interface serial_if;
  logic [6:0] txData;
  logic       txStart;
  logic       txBusy;
  logic [6:0] rxData;
  logic       rxStrobe;
  logic       rxParityErr;
  modport ctrl (output txData, txStart, input txBusy, rxData, rxStrobe, rxParityErr);
  modport link (input txData, txStart, output txBusy, rxData, rxStrobe, rxParityErr);
endinterface
`default_nettype wire

// File: include/ups_pkg.sv
// Purpose: Shared constants and types of the supply status and remote-control block.
// Assumes: A 40 MHz core clock.
// Notes:   Register offsets are byte addresses on the AXI4-Lite bus.
`default_nettype none
package ups_pkg;
  localparam int CLK_HZ         = 40_000_000;
  localparam int ONE_SECOND_S   = 1;
  localparam int SECOND_CYCLES  = ONE_SECOND_S * CLK_HZ;
  localparam int BAUD_RATE      = 1200;
  localparam int BAUD_DIV       = CLK_HZ / BAUD_RATE;
  localparam int SINE_HZ        = 60;
  localparam logic [31:0] SINE_STEP = 32'((64'(SINE_HZ) << 32) / 64'(CLK_HZ));
  localparam int OT_SHUTDOWN_S  = 180;
  localparam int BYPASS_DELAY_S = 2;
  localparam logic [6:0] BATT_LOW_PCT = 7'h23;

  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_TX_DATA  = 8'h10;
  localparam logic [7:0] ADDR_RX_DATA  = 8'h14;

  localparam int CTRL_SW_BYPASS   = 0;
  localparam int CTRL_SW_SHUTDOWN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  localparam int IRQ_RUNNING_ON_BATTERY_N     = 0;
  localparam int IRQ_BATT_LOW    = 1;
  localparam int IRQ_OVER_TEMP   = 2;
  localparam int IRQ_OT_SHUTDOWN = 3;
  localparam int IRQ_RX_CHAR     = 4;
  localparam int IRQ_RX_ERROR    = 5;
  localparam int IRQ_W           = 6;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_ONLINE  = 2'b01,
    ST_OT_SHUT = 2'b10,
    ST_BYPASS  = 2'b11
  } ups_state_t;
endpackage
`default_nettype wire
